// >>> hdl/bit_shift_flag_mcu_execute.sv
// Behaviour
// RULE1: Push stores register, moves pointer down, two cycles, flags kept.
// RULE2: Pop moves pointer up, loads register, two cycles, flags kept.
// RULE3: Set I/O bit forces one bit high, others kept, two cycles, flags kept.
// RULE4: Clear I/O bit zeroes one bit, others kept, two cycles, flags kept.
// RULE5: Left shift inserts zero at bit 0, updates Z C N V, one cycle.
// RULE6: Right shift inserts zero at bit 7, updates Z C N V, one cycle.
// RULE7: Rotate left through carry, old bit 7 to carry, one cycle.
// RULE8: Rotate right through carry, old bit 0 to carry, one cycle.
// RULE9: Arithmetic right shift keeps bit 7, updates Z C N V, one cycle.
// RULE10: Nibble swap exchanges register halves in one cycle, flags kept.
// RULE11: Bit store copies selected register bit into T, only T changes.
// RULE12: Bit load writes T into selected register bit, flags kept.
// RULE13: Overflow set forces V high in one cycle, nothing else.
// RULE14: Overflow clear forces V low in one cycle, nothing else.
// RULE15: Half carry set and clear change only H, one cycle each.
// RULE16: Signed flag set and clear change only S, one cycle each.
// RULE17: Sleep takes one cycle, keeps flags, pulses the sleep request.
// RULE18: Watchdog restart takes one cycle, keeps flags, pulses restart.
// RULE19: Break only signals the debug system and keeps flags.
// RULE20: Port read and write move a byte in one cycle, flags kept.
// RULE21: Carry, zero, negative, interrupt flags set and clear alone.
`timescale 1ns/1ps
module bit_shift_flag_mcu_execute (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    // Request port
    input wire logic I_OP_VALID,
    input wire exec_pkg::op_t I_OP,
    output logic O_OP_READY,
    output logic O_OP_DONE,
    // Core state
    output logic [7:0] O_STATUS,
    output logic [7:0] O_SP,
    // Inspection port
    input wire logic [4:0] I_PEEK_REG,
    input wire logic [5:0] I_PEEK_IO,
    input wire logic [7:0] I_PEEK_STACK,
    output logic [7:0] O_PEEK_REG_DATA,
    output logic [7:0] O_PEEK_IO_DATA,
    output logic [7:0] O_PEEK_STACK_DATA,
    // Control pulses to sleep, watchdog and debug logic
    output logic O_SLEEP_REQ,
    output logic O_WDT_RESTART,
    output logic O_DEBUG_BREAK
);

    logic [7:0] regs [exec_pkg::NUM_REGS];
    logic [7:0] io_mem [exec_pkg::NUM_IO];
    logic [7:0] stack_mem [exec_pkg::STACK_DEPTH];
    logic [7:0] status;
    logic [7:0] sp;
    exec_pkg::exec_state_t state;
    exec_pkg::op_t held;
    logic accept;
    logic is_long;
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [7:0] next_rd;
    logic next_c;
    logic shift_op;

    assign accept = I_OP_VALID && (state == exec_pkg::st_idle);
    assign O_OP_READY = (state == exec_pkg::st_idle);
    assign O_STATUS = status;
    assign O_SP = sp;
    assign rd_val = regs[I_OP.rd];
    assign rr_val = regs[I_OP.rr];

    always_comb begin
        unique case (I_OP.opcode)
            exec_pkg::stack_push_op,
            exec_pkg::stack_pop_op,
            exec_pkg::io_bit_set_op,
            exec_pkg::io_bit_clear_op: is_long = 1'b1;
            default: is_long = 1'b0;
        endcase
    end

    // Shift and rotate datapath
    always_comb begin
        next_rd = rd_val;
        next_c = status[exec_pkg::FLAG_C];
        shift_op = 1'b1;
        unique case (I_OP.opcode)
            exec_pkg::logical_left_shift_op: begin
                next_rd = {rd_val[6:0], 1'b0}; // RULE5
                next_c = rd_val[7];
            end
            exec_pkg::logical_right_shift_op: begin
                next_rd = {1'b0, rd_val[7:1]}; // RULE6
                next_c = rd_val[0];
            end
            exec_pkg::rotate_left_carry_op: begin
                next_rd = {rd_val[6:0], status[exec_pkg::FLAG_C]}; // RULE7
                next_c = rd_val[7];
            end
            exec_pkg::rotate_right_carry_op: begin
                next_rd = {status[exec_pkg::FLAG_C], rd_val[7:1]}; // RULE8
                next_c = rd_val[0];
            end
            exec_pkg::arith_right_shift_op: begin
                next_rd = {rd_val[7], rd_val[7:1]}; // RULE9
                next_c = rd_val[0];
            end
            default: shift_op = 1'b0;
        endcase
    end

    // Sequencing: long operations spend one extra cycle before writing
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            state <= exec_pkg::st_idle;
            held <= '0;
        end else if (accept && is_long) begin
            state <= exec_pkg::st_second; // RULE1 RULE2 RULE3 RULE4
            held <= I_OP;
        end else begin
            state <= exec_pkg::st_idle;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            O_OP_DONE <= 1'b0;
        end else begin
            O_OP_DONE <= (accept && !is_long) ||
                (state == exec_pkg::st_second);
        end
    end

    // Status flags; only the flags an operation names are touched
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            status <= exec_pkg::STATUS_RESET;
        end else if (accept) begin
            if (shift_op) begin // RULE5 RULE6 RULE7 RULE8 RULE9
                status[exec_pkg::FLAG_C] <= next_c;
                status[exec_pkg::FLAG_Z] <= (next_rd == 8'h00);
                status[exec_pkg::FLAG_N] <= next_rd[7];
                status[exec_pkg::FLAG_V] <= next_rd[7] ^ next_c;
            end
            unique case (I_OP.opcode)
                exec_pkg::bit_to_flag_op:
                    status[exec_pkg::FLAG_T] <= rr_val[I_OP.bit_sel]; // RULE11
                // One bit-indexed path serves every single-flag operation
                exec_pkg::flag_set_op: // RULE13 RULE15 RULE16 RULE21
                    status[I_OP.bit_sel] <= 1'b1;
                exec_pkg::flag_clear_op: // RULE14 RULE15 RULE16 RULE21
                    status[I_OP.bit_sel] <= 1'b0;
                default: begin
                end
            endcase
        end
    end

    // General registers
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            for (int i = 0; i < exec_pkg::NUM_REGS; i++) begin
                regs[i] <= 8'h00;
            end
        end else if (state == exec_pkg::st_second) begin
            if (held.opcode == exec_pkg::stack_pop_op) begin
                regs[held.rd] <= stack_mem[sp + 8'h01]; // RULE2
            end
        end else if (accept) begin
            if (shift_op) begin
                regs[I_OP.rd] <= next_rd;
            end
            unique case (I_OP.opcode)
                exec_pkg::nibble_swap_op:
                    regs[I_OP.rd] <= {rd_val[3:0], rd_val[7:4]}; // RULE10
                exec_pkg::flag_to_bit_op:
                    regs[I_OP.rd][I_OP.bit_sel] <=
                        status[exec_pkg::FLAG_T]; // RULE12
                exec_pkg::port_read_op:
                    regs[I_OP.rd] <= io_mem[I_OP.io_addr]; // RULE20
                default: begin
                end
            endcase
        end
    end

    // I/O space; the bit operations are read-modify-write in the second cycle
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            for (int i = 0; i < exec_pkg::NUM_IO; i++) begin
                io_mem[i] <= 8'h00;
            end
        end else if (state == exec_pkg::st_second) begin
            if (held.opcode == exec_pkg::io_bit_set_op) begin
                io_mem[held.io_addr][held.bit_sel] <= 1'b1; // RULE3
            end
            if (held.opcode == exec_pkg::io_bit_clear_op) begin
                io_mem[held.io_addr][held.bit_sel] <= 1'b0; // RULE4
            end
        end else if (accept && I_OP.opcode == exec_pkg::port_write_op) begin
            io_mem[I_OP.io_addr] <= rr_val; // RULE20
        end
    end

    // Stack: post-decrement on push, pre-increment on pop; wraps silently
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            sp <= exec_pkg::SP_RESET;
        end else if (state == exec_pkg::st_second) begin
            if (held.opcode == exec_pkg::stack_push_op) begin
                sp <= sp - 8'h01; // RULE1
            end
            if (held.opcode == exec_pkg::stack_pop_op) begin
                sp <= sp + 8'h01; // RULE2
            end
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (state == exec_pkg::st_second &&
            held.opcode == exec_pkg::stack_push_op) begin
            stack_mem[sp] <= regs[held.rr]; // RULE1
        end
    end

    // Control pulses; the mechanisms themselves live elsewhere
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            O_SLEEP_REQ <= 1'b0;
            O_WDT_RESTART <= 1'b0;
            O_DEBUG_BREAK <= 1'b0;
        end else begin
            O_SLEEP_REQ <= accept &&
                I_OP.opcode == exec_pkg::sleep_op; // RULE17
            O_WDT_RESTART <= accept &&
                I_OP.opcode == exec_pkg::watchdog_restart_op; // RULE18
            O_DEBUG_BREAK <= accept &&
                I_OP.opcode == exec_pkg::debug_break_op; // RULE19
        end
    end

    // Inspection reads; stack memory is not reset so its data is unknown
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            O_PEEK_REG_DATA <= 8'h00;
            O_PEEK_IO_DATA <= 8'h00;
            O_PEEK_STACK_DATA <= 8'h00;
        end else begin
            O_PEEK_REG_DATA <= regs[I_PEEK_REG];
            O_PEEK_IO_DATA <= io_mem[I_PEEK_IO];
            O_PEEK_STACK_DATA <= stack_mem[I_PEEK_STACK];
        end
    end

    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RESET_N);

    a_push_timing: assert property ( // RULE1
        accept && I_OP.opcode == exec_pkg::stack_push_op |=>
            !O_OP_READY && !O_OP_DONE ##1
            O_OP_DONE && sp == $past(sp, 2) - 8'h01 &&
            status == $past(status, 2))
        else $error("push timing or pointer wrong");

    a_pop_timing: assert property ( // RULE2
        accept && I_OP.opcode == exec_pkg::stack_pop_op |=>
            ##1 O_OP_DONE && sp == $past(sp, 2) + 8'h01 &&
            status == $past(status, 2))
        else $error("pop timing or pointer wrong");

    a_io_bit_set: assert property ( // RULE3
        accept && I_OP.opcode == exec_pkg::io_bit_set_op |=>
            ##1 io_mem[held.io_addr] ==
            ($past(io_mem[I_OP.io_addr], 2) | (8'h01 << held.bit_sel)))
        else $error("io bit set wrong");

    a_io_bit_clear: assert property ( // RULE4
        accept && I_OP.opcode == exec_pkg::io_bit_clear_op |=>
            ##1 io_mem[held.io_addr] ==
            ($past(io_mem[I_OP.io_addr], 2) & ~(8'h01 << held.bit_sel)))
        else $error("io bit clear wrong");

    a_shift_flags: assert property ( // RULE5
        accept && shift_op |=> O_OP_DONE &&
            status[exec_pkg::FLAG_C] == $past(next_c) &&
            status[exec_pkg::FLAG_V] ==
            (status[exec_pkg::FLAG_N] ^ status[exec_pkg::FLAG_C]) &&
            status[exec_pkg::FLAG_S] == $past(status[exec_pkg::FLAG_S]))
        else $error("shift flags wrong");

    a_rotate_left: assert property ( // RULE7
        accept && I_OP.opcode == exec_pkg::rotate_left_carry_op |=>
            status[exec_pkg::FLAG_C] == $past(rd_val[7]) &&
            regs[$past(I_OP.rd)] ==
            {$past(rd_val[6:0]), $past(status[exec_pkg::FLAG_C])})
        else $error("rotate left wrong");

    a_arith_shift: assert property ( // RULE9
        accept && I_OP.opcode == exec_pkg::arith_right_shift_op |=>
            regs[$past(I_OP.rd)] == {$past(rd_val[7]), $past(rd_val[7:1])})
        else $error("arithmetic shift wrong");

    a_nibble_swap: assert property ( // RULE10
        accept && I_OP.opcode == exec_pkg::nibble_swap_op |=>
            status == $past(status) &&
            regs[$past(I_OP.rd)] == {$past(rd_val[3:0]), $past(rd_val[7:4])})
        else $error("nibble swap wrong");

    a_bit_store: assert property ( // RULE11
        accept && I_OP.opcode == exec_pkg::bit_to_flag_op |=>
            status[exec_pkg::FLAG_T] == $past(rr_val[I_OP.bit_sel]) &&
            status[5:0] == $past(status[5:0]))
        else $error("bit store wrong");

    a_flag_set_one: assert property ( // RULE13
        accept && I_OP.opcode == exec_pkg::flag_set_op |=>
            status == ($past(status) | (8'h01 << $past(I_OP.bit_sel))))
        else $error("flag set wrong");

    a_ctrl_pulses: assert property ( // RULE17
        accept && I_OP.opcode == exec_pkg::sleep_op |=>
            O_SLEEP_REQ && O_OP_DONE && status == $past(status) ##1
            O_SLEEP_REQ == ($past(accept) &&
            $past(I_OP.opcode) == exec_pkg::sleep_op))
        else $error("sleep pulse wrong");

    a_wdt_pulse: assert property ( // RULE18
        O_WDT_RESTART |-> $past(accept) &&
            $past(I_OP.opcode) == exec_pkg::watchdog_restart_op)
        else $error("watchdog pulse without cause");

    c_push_pop: cover property (
        accept && I_OP.opcode == exec_pkg::stack_push_op ##2
        accept && I_OP.opcode == exec_pkg::stack_pop_op);
    c_rotate_carry: cover property (
        accept && I_OP.opcode == exec_pkg::rotate_right_carry_op &&
        status[exec_pkg::FLAG_C]);
    c_io_set: cover property (
        accept && I_OP.opcode == exec_pkg::io_bit_set_op);
    c_break: cover property (O_DEBUG_BREAK);

endmodule : bit_shift_flag_mcu_execute

// >>> hdl/exec_pkg.sv
package exec_pkg;

    // Operation codes presented on the request port
    typedef enum logic [4:0] {
        no_op = 5'h00,
        port_read_op = 5'h01,
        port_write_op = 5'h02,
        stack_push_op = 5'h03,
        stack_pop_op = 5'h04,
        io_bit_set_op = 5'h05,
        io_bit_clear_op = 5'h06,
        logical_left_shift_op = 5'h07,
        logical_right_shift_op = 5'h08,
        rotate_left_carry_op = 5'h09,
        rotate_right_carry_op = 5'h0A,
        arith_right_shift_op = 5'h0B,
        nibble_swap_op = 5'h0C,
        bit_to_flag_op = 5'h0D,
        flag_to_bit_op = 5'h0E,
        flag_set_op = 5'h0F,
        flag_clear_op = 5'h10,
        sleep_op = 5'h11,
        watchdog_restart_op = 5'h12,
        debug_break_op = 5'h13
    } opcode_t;

    // One request: operands are ignored by operations that do not use them
    typedef struct packed {
        opcode_t opcode;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [2:0] bit_sel;
        logic [5:0] io_addr;
    } op_t;

    typedef enum logic [0:0] {
        st_idle = 1'b0,
        st_second = 1'b1
    } exec_state_t;

    // Bit positions inside status_flags_register
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] SP_RESET = 8'hFF;
    localparam int NUM_REGS = 32;
    localparam int NUM_IO = 64;
    localparam int STACK_DEPTH = 256;

    // Cycle counts per operation class
    localparam int CYCLES_SHORT = 1;
    localparam int CYCLES_LONG = 2;

endpackage : exec_pkg

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk;
    logic rst_n;
    logic op_valid;
    exec_pkg::op_t op;
    logic op_ready;
    logic op_done;
    logic sleep_req;
    logic wdt_restart;
    logic dbg_break;
    logic [7:0] status;
    logic [7:0] sp;
    logic [4:0] peek_reg;
    logic [5:0] peek_io;
    logic [7:0] peek_stack;
    logic [7:0] reg_d;
    logic [7:0] io_d;
    logic [7:0] stack_d;
    logic [7:0] exp_st;
    logic [2:0] pulses;
    int errors;
    int check_count;

    bit_shift_flag_mcu_execute u_bit_shift_flag_mcu_execute (
        .I_REF_CLK(clk), .I_RESET_N(rst_n),
        .I_OP_VALID(op_valid), .I_OP(op),
        .O_OP_READY(op_ready), .O_OP_DONE(op_done),
        .O_STATUS(status), .O_SP(sp),
        .I_PEEK_REG(peek_reg), .I_PEEK_IO(peek_io),
        .I_PEEK_STACK(peek_stack), .O_PEEK_REG_DATA(reg_d),
        .O_PEEK_IO_DATA(io_d), .O_PEEK_STACK_DATA(stack_d),
        .O_SLEEP_REQ(sleep_req), .O_WDT_RESTART(wdt_restart),
        .O_DEBUG_BREAK(dbg_break)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task automatic chk8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    function automatic exec_pkg::op_t mk(exec_pkg::opcode_t oc,
        logic [4:0] rd, logic [4:0] rr, logic [2:0] b, logic [5:0] a);
        mk = '{oc, rd, rr, b, a};
    endfunction : mk

    // Caller sets exp_st first; every operation re-checks all flags
    task automatic issue(input exec_pkg::op_t o, input int cyc);
        int n;
        @(posedge clk);
        op_valid <= 1'b1;
        op <= o;
        n = 0;
        do begin
            @(posedge clk);
            if (n == 0) op_valid <= 1'b0;
            #1;
            n++;
            if (n == 1 && cyc == 2)
                chk8("ready while busy", 8'h00, {7'h00, op_ready});
        end while (op_done !== 1'b1 && n < 4);
        chk8("cycles", 8'(cyc), 8'(n));
        chk8("status", exp_st, status);
        pulses = {sleep_req, wdt_restart, dbg_break};
    endtask : issue

    // Peek data is registered, so wait two edges after the address
    task automatic peek(input logic [4:0] r, input logic [5:0] a,
                        input logic [7:0] s);
        @(posedge clk);
        peek_reg <= r;
        peek_io <= a;
        peek_stack <= s;
        repeat (2) @(posedge clk);
        #1;
    endtask : peek

    // No load-immediate exists, so bytes are built in a scratch I/O slot
    task automatic load_reg(input logic [4:0] r, input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            issue(mk(v[i] ? exec_pkg::io_bit_set_op
                : exec_pkg::io_bit_clear_op, 5'h00, 5'h00, 3'(i),
                6'h3F), 2);
        issue(mk(exec_pkg::port_read_op, r, 5'h00, 3'h0, 6'h3F), 1);
    endtask : load_reg

    task automatic flag(input int b, input logic v);
        exp_st[b] = v;
        issue(mk(v ? exec_pkg::flag_set_op : exec_pkg::flag_clear_op,
            5'h00, 5'h00, 3'(b), 6'h00), 1);
    endtask : flag

    task automatic test_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        exp_st = 8'h00;
        peek(5'h04, 6'h05, 8'h00);
        chk8("status", 8'h00, status);
        chk8("sp", 8'hFF, sp);
        chk8("ready", 8'h01, {7'h00, op_ready});
        chk8("reg", 8'h00, reg_d);
        chk8("io", 8'h00, io_d);
        $display("test reset done");
    endtask : test_reset

    task automatic test_io();
        issue(mk(exec_pkg::io_bit_set_op, '0, '0, 3'h3, 6'h05), 2);
        issue(mk(exec_pkg::io_bit_set_op, '0, '0, 3'h7, 6'h05), 2);
        issue(mk(exec_pkg::io_bit_clear_op, '0, '0, 3'h3, 6'h05), 2);
        load_reg(5'h02, 8'hA5);
        issue(mk(exec_pkg::port_write_op, '0, 5'h02, '0, 6'h06), 1);
        peek(5'h02, 6'h05, 8'h00);
        chk8("io bits", 8'h80, io_d);
        chk8("port read", 8'hA5, reg_d);
        peek(5'h02, 6'h06, 8'h00);
        chk8("port write", 8'hA5, io_d);
        $display("test io done");
    endtask : test_io

    task automatic test_stack();
        load_reg(5'h01, 8'h3C);
        issue(mk(exec_pkg::stack_push_op, '0, 5'h01, '0, '0), 2);
        chk8("sp push", 8'hFE, sp);
        issue(mk(exec_pkg::stack_push_op, '0, 5'h02, '0, '0), 2);
        peek(5'h00, 6'h00, 8'hFF);
        chk8("stack", 8'h3C, stack_d);
        issue(mk(exec_pkg::stack_pop_op, 5'h04, '0, '0, '0), 2);
        chk8("sp pop", 8'hFE, sp);
        issue(mk(exec_pkg::stack_pop_op, 5'h07, '0, '0, '0), 2);
        chk8("sp pop", 8'hFF, sp);
        peek(5'h04, 6'h00, 8'h00);
        chk8("pop last", 8'hA5, reg_d);
        peek(5'h07, 6'h00, 8'h00);
        chk8("pop first", 8'h3C, reg_d);
        $display("test stack done");
    endtask : test_stack

    task automatic test_shifts();
        exec_pkg::opcode_t ops[5] = '{exec_pkg::logical_left_shift_op,
            exec_pkg::logical_right_shift_op,
            exec_pkg::rotate_left_carry_op,
            exec_pkg::rotate_right_carry_op,
            exec_pkg::arith_right_shift_op};
        logic [7:0] vals[5] = '{8'h81, 8'h01, 8'h80, 8'h01, 8'h81};
        logic [7:0] v;
        logic [8:0] r;
        logic c;
        flag(exec_pkg::FLAG_S, 1'b1);
        flag(exec_pkg::FLAG_H, 1'b1);
        for (int k = 0; k < 10; k++) begin
            v = vals[k % 5];
            c = (k >= 5);
            flag(exec_pkg::FLAG_C, c);
            load_reg(5'h03, v);
            case (ops[k % 5])
                exec_pkg::logical_left_shift_op: r = {v, 1'b0};
                exec_pkg::logical_right_shift_op: r = {v[0], 1'b0, v[7:1]};
                exec_pkg::rotate_left_carry_op: r = {v, c};
                exec_pkg::rotate_right_carry_op: r = {v[0], c, v[7:1]};
                default: r = {v[0], v[7], v[7:1]};
            endcase
            exp_st[exec_pkg::FLAG_C] = r[8];
            exp_st[exec_pkg::FLAG_Z] = (r[7:0] == 8'h00);
            exp_st[exec_pkg::FLAG_N] = r[7];
            exp_st[exec_pkg::FLAG_V] = r[7] ^ r[8];
            issue(mk(ops[k % 5], 5'h03, '0, '0, '0),
                1);
            peek(5'h03, 6'h00, 8'h00);
            chk8("shift result", r[7:0],
                reg_d);
        end
        $display("test shifts done");
    endtask : test_shifts

    task automatic test_bits();
        load_reg(5'h05, 8'h3A);
        issue(mk(exec_pkg::nibble_swap_op, 5'h05, '0, '0, '0), 1);
        exp_st[exec_pkg::FLAG_T] = 1'b1;
        issue(mk(exec_pkg::bit_to_flag_op, '0, 5'h05, 3'h7, '0), 1);
        issue(mk(exec_pkg::flag_to_bit_op, 5'h06, '0, 3'h2, '0), 1);
        exp_st[exec_pkg::FLAG_T] = 1'b0;
        issue(mk(exec_pkg::bit_to_flag_op, '0, 5'h05, 3'h6, '0), 1);
        peek(5'h05, 6'h00, 8'h00);
        chk8("swap", 8'hA3, reg_d);
        peek(5'h06, 6'h00, 8'h00);
        chk8("bit load", 8'h04, reg_d);
        // A cleared T must also clear a set bit, not only set a clear one
        issue(mk(exec_pkg::flag_to_bit_op, 5'h05, '0, 3'h7, '0), 1);
        peek(5'h05, 6'h00, 8'h00);
        chk8("bit load zero", 8'h23, reg_d);
        $display("test bits done");
    endtask : test_bits

    task automatic test_flags();
        for (int b = 0; b < 8; b++) begin
            flag(b, 1'b1);
            flag(b, 1'b0);
        end
        $display("test flags done");
    endtask : test_flags

    task automatic test_control();
        exec_pkg::opcode_t ops[4] = '{exec_pkg::sleep_op,
            exec_pkg::watchdog_restart_op, exec_pkg::debug_break_op,
            exec_pkg::no_op};
        logic [2:0] exp[4] = '{3'b100, 3'b010, 3'b001, 3'b000};
        for (int k = 0; k < 4; k++) begin
            issue(mk(ops[k], '0, '0, '0, '0), 1);
            chk8("pulses", {5'h00, exp[k]},
                {5'h00, pulses});
        end
        $display("test control done");
    endtask : test_control

    // Bound is more than thirty times the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out();
    end

    initial begin
        errors = 0;
        check_count = 0;
        rst_n = 1'b0;
        op_valid = 1'b0;
        op = '0;
        peek_reg = 5'h00;
        peek_io = 6'h00;
        peek_stack = 8'h00;
        exp_st = 8'h00;
        pulses = 3'b000;
        test_reset();
        test_io();
        test_stack();
        test_shifts();
        test_bits();
        test_flags();
        test_control();
        test_reset();
        close_out();
    end
endmodule : tb_top
